// >>> ifm_pkg.sv
/*
 * Shared constants, types and helper functions for the instruction format
 * decoder and its indexed data moves.
 * Assumes a 12-bit data address space and 16-bit instruction words.
 */
package ifm_pkg;

  // Instruction cycle phases, one reference clock each.
  localparam logic [1:0] PH_Q1 = 2'h0;
  localparam logic [1:0] PH_Q2 = 2'h1;
  localparam logic [1:0] PH_Q3 = 2'h2;
  localparam logic [1:0] PH_Q4 = 2'h3;
  localparam logic [1:0] PH_LAST = PH_Q4;

  // Opcode patterns used to classify the first word and to check the second.
  localparam logic [8:0] OPC_IDX_MOVE = 9'h1D7;  // Word bits 15..7.
  localparam logic [7:0] OPC_PUSH_LIT = 8'hFA;   // Word bits 15..8.
  localparam logic [3:0] OPC_F2F_MOVE = 4'hC;    // Word bits 15..12.
  localparam logic [7:0] OPC_JUMP = 8'hEF;       // Word bits 15..8.
  localparam logic [6:0] OPC_CALL = 7'h76;       // Word bits 15..9.
  localparam logic [3:0] NIB_BIT_LO = 4'h7;      // Bit-oriented group, low nibble.
  localparam logic [3:0] NIB_BIT_HI = 4'hB;      // Bit-oriented group, high nibble.
  localparam logic [3:0] NIB_LITERAL = 4'h0;     // Literal group nibble.
  localparam logic [3:0] SECOND_TAG = 4'hF;      // Top nibble of every second word.

  // Access bank split and the banks it maps to.
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hF;

  // Indirect-addressing register windows, each INDIR_SPAN bytes long.
  localparam logic [11:0] INDIR_BASE0 = 12'hFEB;
  localparam logic [11:0] INDIR_BASE1 = 12'hFE3;
  localparam logic [11:0] INDIR_BASE2 = 12'hFDB;
  localparam logic [11:0] INDIR_SPAN = 12'h005;

  // Frame pointer value after reset, and the byte an indirect source reads as.
  localparam logic [11:0] FP_RST = 12'h000;
  localparam logic [7:0] READ_INDIRECT_VAL = 8'h00;

  // Decoded instruction format.
  typedef enum logic [8:0] {
    FMT_NONE = 9'h001,
    FMT_BYTE = 9'h002,
    FMT_BIT = 9'h004,
    FMT_LIT = 9'h008,
    FMT_F2F = 9'h010,
    FMT_JUMP = 9'h020,
    FMT_CALL = 9'h040,
    FMT_IDX = 9'h080,
    FMT_PUSH = 9'h100
  } ifm_fmt_e;

  // Sequencer state: idle, or waiting for / executing a second word.
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_F2F2 = 5'h02,
    ST_JMP2 = 5'h04,
    ST_IDX2 = 5'h08,
    ST_IDXW = 5'h10
  } ifm_st_e;

  // True when the address falls in one of the indirect register windows.
  function automatic logic is_indirect(input logic [11:0] a);
    logic [11:0] r0;
    logic [11:0] r1;
    logic [11:0] r2;
    r0 = a - INDIR_BASE0;
    r1 = a - INDIR_BASE1;
    r2 = a - INDIR_BASE2;
    return (r0 < INDIR_SPAN) || (r1 < INDIR_SPAN) || (r2 < INDIR_SPAN);
  endfunction

  // Full data address from the bank-access flag, bank select and 8-bit file address.
  function automatic logic [11:0] bank_addr(input logic banked, input logic [3:0] bank,
                                            input logic [7:0] f);
    logic [3:0] b;
    if (banked) begin
      b = bank;
    end else if (f >= ACCESS_SPLIT) begin
      b = ACCESS_HI_BANK;
    end else begin
      b = ACCESS_LO_BANK;
    end
    return {b, f};
  endfunction

endpackage

// >>> ifm_phase.sv
/*
 * Four-phase sequencer that splits each instruction cycle into Q1..Q4.
 * Assumes one reference clock and a synchronous active-low reset.
 */
`timescale 1ns/10ps
module ifm_phase
  import ifm_pkg::*;
(
  input wire logic ref_clk_i,     // Reference clock.
  input wire logic rst_n_i,       // Synchronous reset, active low.
  output logic [1:0] phase_o,     // Current phase, Q1 first.
  output logic q1_o               // High during phase Q1.
);

  typedef struct packed {
    logic [1:0] ph;
    logic q1;
  } ifm_phase_s;

  ifm_phase_s s_q;
  ifm_phase_s s_d;

  // Next phase wraps after Q4; the Q1 flag rises at the same edge as the count enters Q1.
  always_comb begin
    s_d = s_q;
    s_d.ph = (s_q.ph == PH_LAST) ? PH_Q1 : s_q.ph + 2'h1;
    s_d.q1 = (s_q.ph == PH_LAST);
  end

  // Reset lands in Q1 so the first instruction word is taken at once.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      s_q <= '{ph: PH_Q1, q1: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  assign phase_o = s_q.ph;
  assign q1_o = s_q.q1;

endmodule

// >>> ifm_decoder.sv
/*
 * Instruction format decoder with indexed move and push-literal execution.
 * Assumes program memory offers a word in Q1 and data memory answers
 * reads combinationally within the strobe cycle, all on ref_clk_i.
 */
// What this block does
// - Byte ops: opcode bits 15-10, destination flag 9, bank flag 8, address 7-0.
// - Destination flag zero sends result to working register, one to file.
// - Bank flag zero uses access bank; one uses bank select register.
// - File-to-file move: 12-bit source, then 1111 word with 12-bit destination.
// - Bit ops: bit position bits 11-9, bank flag 8, address 7-0.
// - Literal ops: opcode bits 15-8, immediate bits 7-0.
// - Jump/call target: 8 low bits, then 12 bits from 1111 word; fast flag.
// - Indexed move is two words, each carrying a 7-bit offset.
// - Source and destination are frame pointer plus their offsets.
// - Copy source byte to destination; source and frame pointer untouched.
// - Computed addresses reach the whole 4096-byte data space.
// - Indirect register as source reads as 00h without access.
`timescale 1ns/10ps
module ifm_decoder
  import ifm_pkg::*;
(
  input wire logic ref_clk_i,             // Reference clock, 20 MHz.
  input wire logic rst_n_i,               // Synchronous reset, active low.
  input wire logic instr_valid_i,         // Instruction word available.
  input wire logic [15:0] instr_word_i,   // Instruction word from program memory.
  input wire logic [3:0] bank_sel_i,      // Bank select register value.
  input wire logic fp_load_i,             // Load the frame pointer.
  input wire logic [11:0] fp_load_val_i,  // Frame pointer load value.
  input wire logic [7:0] mem_rdata_i,     // Data memory read data.
  output logic q1_o,                      // Phase Q1: word is taken this cycle.
  output logic dec_strobe_o,              // Pulse: a word was just taken.
  output logic word_err_o,                // Pulse: second word lacked its tag.
  output logic [8:0] fmt_o,               // One-hot decoded format.
  output logic [5:0] opcode_o,            // Byte-op opcode field.
  output logic result_to_file_o,          // Result goes to the file register.
  output logic bank_access_o,             // Bank select supplies the bank.
  output logic [2:0] bit_pos_o,           // Bit position field.
  output logic [7:0] literal_o,           // Immediate operand.
  output logic [11:0] file_addr_o,        // Full file address.
  output logic [11:0] f2f_src_o,          // File-to-file source address.
  output logic [11:0] f2f_dst_o,          // File-to-file destination address.
  output logic [19:0] target_o,           // Jump or call target.
  output logic fast_return_o,             // Call fast-return flag.
  output logic [11:0] frame_pointer_o,    // Frame pointer.
  output logic [11:0] mem_addr_o,         // Data memory address.
  output logic mem_rd_o,                  // Data memory read strobe.
  output logic mem_wr_o,                  // Data memory write strobe.
  output logic [7:0] mem_wdata_o          // Data memory write data.
);

  typedef struct packed {
    ifm_st_e st;
    ifm_fmt_e fmt;
    logic [5:0] opc;
    logic to_file;
    logic banked;
    logic [2:0] bitpos;
    logic [7:0] lit;
    logic [11:0] faddr;
    logic [11:0] src;
    logic [11:0] dst;
    logic [19:0] tgt;
    logic fast;
    logic [6:0] off;
    logic [7:0] hold;
    logic push;
    logic [11:0] fp;
    logic [11:0] maddr;
    logic mrd;
    logic mwr;
    logic [7:0] mwd;
    logic stb;
    logic err;
  } ifm_state_s;

  ifm_state_s s_q;
  ifm_state_s s_d;
  logic [1:0] phase;
  logic q1;

  // Phase sequencer shared by the whole block.
  ifm_phase u_phase (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .phase_o(phase),
    .q1_o(q1)
  );

  // Decode, address and strobe sequencing across the four phases.
  always_comb begin
    logic [15:0] w;
    w = instr_word_i;
    s_d = s_q;
    s_d.stb = 1'b0;
    s_d.err = 1'b0;
    s_d.mrd = 1'b0;
    s_d.mwr = 1'b0;
    if (fp_load_i) begin
      s_d.fp = fp_load_val_i;
    end
    case (phase)
      PH_Q1: begin
        if (instr_valid_i) begin
          s_d.stb = 1'b1;
          if (s_q.st != ST_IDLE) begin
            // Second words must carry the 1111 tag, else the instruction is dropped.
            s_d.st = ST_IDLE;
            if (w[15:12] != SECOND_TAG) begin
              s_d.err = 1'b1;
              s_d.fmt = FMT_NONE;
            end else if (s_q.st == ST_F2F2) begin
              s_d.dst = w[11:0];
            end else if (s_q.st == ST_JMP2) begin
              s_d.tgt[19:8] = w[11:0];
            end else begin
              s_d.off = w[6:0];
              s_d.st = ST_IDXW;
            end
          end else if (w[15:7] == OPC_IDX_MOVE) begin
            s_d.fmt = FMT_IDX;
            s_d.off = w[6:0];
            s_d.st = ST_IDX2;
          end else if (w[15:8] == OPC_PUSH_LIT) begin
            s_d.fmt = FMT_PUSH;
            s_d.lit = w[7:0];
            s_d.push = 1'b1;
          end else if (w[15:12] == OPC_F2F_MOVE) begin
            s_d.fmt = FMT_F2F;
            s_d.src = w[11:0];
            s_d.st = ST_F2F2;
          end else if (w[15:8] == OPC_JUMP || w[15:9] == OPC_CALL) begin
            s_d.fmt = (w[15:8] == OPC_JUMP) ? FMT_JUMP : FMT_CALL;
            s_d.tgt = {12'h000, w[7:0]};
            s_d.fast = (w[15:9] == OPC_CALL) & w[8];
            s_d.st = ST_JMP2;
          end else if (w[15:12] >= NIB_BIT_LO && w[15:12] <= NIB_BIT_HI) begin
            s_d.fmt = FMT_BIT;
            s_d.bitpos = w[11:9];
            s_d.banked = w[8];
            s_d.faddr = bank_addr(w[8], bank_sel_i, w[7:0]);
          end else if (w[15:12] == NIB_LITERAL) begin
            s_d.fmt = FMT_LIT;
            s_d.lit = w[7:0];
          end else begin
            s_d.fmt = FMT_BYTE;
            s_d.opc = w[15:10];
            s_d.to_file = w[9];
            s_d.banked = w[8];
            s_d.faddr = bank_addr(w[8], bank_sel_i, w[7:0]);
          end
        end
      end
      PH_Q2: begin
        // Frame-relative address; the 12-bit sum wraps over the full space.
        if (s_q.st == ST_IDX2 || s_q.st == ST_IDXW) begin
          s_d.maddr = s_q.fp + {5'h00, s_q.off};
        end
      end
      PH_Q3: begin
        if (s_q.st == ST_IDX2) begin
          s_d.mrd = !is_indirect(s_q.maddr);
          s_d.hold = READ_INDIRECT_VAL;
        end else if (s_q.st == ST_IDXW) begin
          s_d.mwr = !is_indirect(s_q.maddr);
          s_d.mwd = s_q.hold;
        end else if (s_q.push) begin
          s_d.maddr = s_q.fp;
          s_d.mwd = s_q.lit;
          s_d.mwr = 1'b1;
        end
      end
      PH_Q4: begin
        if (s_q.mrd) begin
          s_d.hold = mem_rdata_i;
        end
        if (s_q.st == ST_IDXW) begin
          s_d.st = ST_IDLE;
        end
        // The push decrement wins over a frame pointer load at the same edge.
        if (s_q.push) begin
          s_d.fp = s_q.fp - 12'h001;
          s_d.push = 1'b0;
        end
      end
      default: ;
    endcase
  end

  // Single state register for the whole block apart from the phase sequencer.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      s_q <= '{st: ST_IDLE, fmt: FMT_NONE, fp: FP_RST, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // Every output is a field of the state register or the phase flop.
  assign q1_o = q1;
  assign dec_strobe_o = s_q.stb;
  assign word_err_o = s_q.err;
  assign fmt_o = s_q.fmt;
  assign opcode_o = s_q.opc;
  assign result_to_file_o = s_q.to_file;
  assign bank_access_o = s_q.banked;
  assign bit_pos_o = s_q.bitpos;
  assign literal_o = s_q.lit;
  assign file_addr_o = s_q.faddr;
  assign f2f_src_o = s_q.src;
  assign f2f_dst_o = s_q.dst;
  assign target_o = s_q.tgt;
  assign fast_return_o = s_q.fast;
  assign frame_pointer_o = s_q.fp;
  assign mem_addr_o = s_q.maddr;
  assign mem_rd_o = s_q.mrd;
  assign mem_wr_o = s_q.mwr;
  assign mem_wdata_o = s_q.mwd;

  // Checks on decoded fields and data moves.
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_byte_fields;
    dec_strobe_o && fmt_o == FMT_BYTE |-> opcode_o == $past(instr_word_i[15:10])
      && bank_access_o == $past(instr_word_i[8]);
  endproperty
  a_byte_fields: assert property (p_byte_fields) else $error("byte fields wrong");

  property p_dest_flag;
    dec_strobe_o && fmt_o == FMT_BYTE |-> result_to_file_o == $past(instr_word_i[9]);
  endproperty
  a_dest_flag: assert property (p_dest_flag) else $error("destination flag wrong");

  property p_banked_addr;
    dec_strobe_o && fmt_o == FMT_BIT && bank_access_o
      |-> file_addr_o == {$past(bank_sel_i), $past(instr_word_i[7:0])};
  endproperty
  a_banked_addr: assert property (p_banked_addr) else $error("banked address wrong");

  property p_f2f_dst;
    dec_strobe_o && !word_err_o && $past(s_q.st) == ST_F2F2
      |-> f2f_dst_o == $past(instr_word_i[11:0]);
  endproperty
  a_f2f_dst: assert property (p_f2f_dst) else $error("move destination wrong");

  property p_bit_pos;
    dec_strobe_o && fmt_o == FMT_BIT |-> bit_pos_o == $past(instr_word_i[11:9]);
  endproperty
  a_bit_pos: assert property (p_bit_pos) else $error("bit position wrong");

  property p_literal;
    dec_strobe_o && fmt_o == FMT_LIT |-> literal_o == $past(instr_word_i[7:0]);
  endproperty
  a_literal: assert property (p_literal) else $error("literal wrong");

  property p_target;
    dec_strobe_o && !word_err_o && $past(s_q.st) == ST_JMP2
      |-> target_o == {$past(instr_word_i[11:0]), $past(target_o[7:0])};
  endproperty
  a_target: assert property (p_target) else $error("target wrong");

  // The address was formed in Q2, so a frame pointer load since then must not matter.
  property p_idx_write;
    mem_wr_o && s_q.st == ST_IDXW
      |-> mem_wdata_o == s_q.hold
      && mem_addr_o == $past(frame_pointer_o, 2) + {5'h00, s_q.off};
  endproperty
  a_idx_write: assert property (p_idx_write) else $error("indexed write wrong");

  property p_no_indirect;
    (mem_rd_o || (mem_wr_o && fmt_o == FMT_IDX)) |-> !is_indirect(mem_addr_o);
  endproperty
  a_no_indirect: assert property (p_no_indirect) else $error("indirect access made");

  // The push address was taken from the frame pointer as it stood in Q3.
  property p_push;
    mem_wr_o && fmt_o == FMT_PUSH
      |-> mem_addr_o == $past(frame_pointer_o)
      ##1 frame_pointer_o == $past(frame_pointer_o) - 12'h001;
  endproperty
  a_push: assert property (p_push) else $error("push literal wrong");

  c_push: cover property (mem_wr_o && fmt_o == FMT_PUSH);
  c_idx_move: cover property (mem_wr_o && s_q.st == ST_IDXW);
  c_idx_zero: cover property (s_q.st == ST_IDX2 && phase == PH_Q4 && !mem_rd_o);
  c_jump: cover property (dec_strobe_o && $past(s_q.st) == ST_JMP2 && !word_err_o);

endmodule

// >>> ifm_dmem_model.sv
/*
 * Behavioural data memory that faces the decoder's data port.
 * Assumes reads are answered within the strobe cycle and writes land at its ending edge.
 */
`timescale 1ns/10ps
module ifm_dmem_model (
  input wire logic ref_clk_i,      // Reference clock.
  input wire logic [11:0] addr_i,  // Byte address.
  input wire logic rd_i,           // Read strobe.
  input wire logic wr_i,           // Write strobe.
  input wire logic [7:0] wdata_i,  // Write data.
  output logic [7:0] rdata_o       // Read data, valid only while rd_i is high.
);
  logic [7:0] mem_q [4096];
  logic [7:0] junk_q;

  // Fill the array with a pattern that the bench recomputes on its own.
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem_q[i] = 8'(i * 37 + 11);
    end
    junk_q = 8'h5A;
  end

  // Store written bytes; the idle bus toggles so stale data never looks valid.
  always @(posedge ref_clk_i) begin
    if (wr_i) begin
      mem_q[addr_i] <= wdata_i;
    end
    junk_q <= ~junk_q;
  end

  // Data shows only during a read strobe.
  assign rdata_o = rd_i ? mem_q[addr_i] : junk_q;
endmodule

// >>> ifm_decoder_tb.sv
/*
 * Self-checking bench for the instruction format decoder.
 * Assumes the data memory model answers reads in the strobe cycle.
 */
`timescale 1ns/10ps
module ifm_decoder_tb;
  import ifm_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic instr_valid_i = 1'b0;
  logic [15:0] instr_word_i = 16'h0000;
  logic [3:0] bank_sel_i = 4'h0;
  logic fp_load_i = 1'b0;
  logic [11:0] fp_load_val_i = 12'h000;
  logic [7:0] mem_rdata_i;
  logic q1_o, dec_strobe_o, word_err_o, result_to_file_o, bank_access_o, fast_return_o;
  logic mem_rd_o, mem_wr_o;
  logic [8:0] fmt_o;
  logic [5:0] opcode_o;
  logic [2:0] bit_pos_o;
  logic [7:0] literal_o, mem_wdata_o;
  logic [11:0] file_addr_o, f2f_src_o, f2f_dst_o, frame_pointer_o, mem_addr_o;
  logic [19:0] target_o;
  int error_cnt = 0;
  int compares = 0;
  logic [7:0] exp_mem [4096];
  logic [11:0] fp_m = 12'h000;
  logic [3:0] bank;
  logic [11:0] rq[$];
  logic [11:0] wqa[$];
  logic [7:0] wqd[$];
  logic [15:0] w;
  logic [7:0] op;
  logic [11:0] h;
  logic [3:0] nibs [7] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hD};
  logic [25:0] itab [7] = '{{12'h080, 7'h05, 7'h06}, {12'hF80, 7'h7F, 7'h00},
    {12'hF90, 7'h7F, 7'h70}, {12'hFD0, 7'h0B, 7'h00}, {12'hFD0, 7'h00, 7'h13},
    {12'hFD0, 7'h0A, 7'h18}, {12'hFD0, 7'h0F, 7'h17}};

  ifm_decoder DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .instr_valid_i(instr_valid_i),
    .instr_word_i(instr_word_i), .bank_sel_i(bank_sel_i), .fp_load_i(fp_load_i),
    .fp_load_val_i(fp_load_val_i), .mem_rdata_i(mem_rdata_i), .q1_o(q1_o),
    .dec_strobe_o(dec_strobe_o), .word_err_o(word_err_o), .fmt_o(fmt_o), .opcode_o(opcode_o),
    .result_to_file_o(result_to_file_o), .bank_access_o(bank_access_o), .bit_pos_o(bit_pos_o),
    .literal_o(literal_o), .file_addr_o(file_addr_o), .f2f_src_o(f2f_src_o),
    .f2f_dst_o(f2f_dst_o), .target_o(target_o), .fast_return_o(fast_return_o),
    .frame_pointer_o(frame_pointer_o), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o),
    .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o));

  ifm_dmem_model u_dmem (.ref_clk_i(ref_clk_i), .addr_i(mem_addr_o), .rd_i(mem_rd_o),
    .wr_i(mem_wr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));

  // Free-running 20 MHz clock.
  initial begin
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  // Prints the verdict and ends the run.
  task automatic tally_and_finish();
    if (error_cnt == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // True for addresses inside the indirect register windows.
  function automatic bit ind(input logic [11:0] a);
    return (a >= 12'hFDB && a <= 12'hFDF) || (a >= 12'hFE3 && a <= 12'hFE7) ||
      (a >= 12'hFEB && a <= 12'hFEF);
  endfunction

  // Expected full file address from the bank flag and the 8-bit address.
  function automatic logic [11:0] efa(input logic [15:0] x, input logic [3:0] b);
    if (x[8]) begin
      return {b, x[7:0]};
    end
    return (x[7:0] < 8'h60) ? {4'h0, x[7:0]} : {4'hF, x[7:0]};
  endfunction

  // Offers one word in Q1, then scribbles stray words that must be ignored.
  task automatic issue(input logic [15:0] x);
    int n;
    n = 0;
    while (q1_o !== 1'b1 && n < 8) begin
      @(negedge ref_clk_i);
      n++;
    end
    bank = 4'($urandom);
    instr_valid_i = 1'b1;
    instr_word_i = x;
    bank_sel_i = bank;
    @(negedge ref_clk_i);
    instr_valid_i = 1'($urandom);
    instr_word_i = 16'($urandom);
    bank_sel_i = 4'($urandom);
    chk(dec_strobe_o, 20'h1);
  endtask

  // Loads the frame pointer for one cycle.
  task automatic fp_load(input logic [11:0] v);
    fp_load_i = 1'b1;
    fp_load_val_i = v;
    @(negedge ref_clk_i);
    fp_load_i = 1'b0;
    fp_m = v;
    chk(frame_pointer_o, v);
  endtask

  // Indexed move: queue the expected read and write, then send both words.
  task automatic idx(input logic [6:0] zs, input logic [6:0] zd);
    logic [11:0] s, d;
    logic [7:0] v;
    s = fp_m + 12'(zs);
    d = fp_m + 12'(zd);
    v = ind(s) ? 8'h00 : exp_mem[s];
    if (!ind(s)) begin
      rq.push_back(s);
    end
    if (!ind(d)) begin
      wqa.push_back(d);
      wqd.push_back(v);
      exp_mem[d] = v;
    end
    issue({8'hEB, 1'b1, zs});
    chk(fmt_o, FMT_IDX);
    issue({4'hF, 5'($urandom), zd});
    chk(word_err_o, 20'h0);
    chk(frame_pointer_o, fp_m);
  endtask

  // Watches the data port against the queued expectations.
  always @(negedge ref_clk_i) begin
    if (mem_rd_o === 1'b1) begin
      if (rq.size() == 0) begin
        chk(20'h1, 20'h0);
      end else begin
        chk(mem_addr_o, rq.pop_front());
      end
    end
    if (mem_wr_o === 1'b1) begin
      if (wqa.size() == 0) begin
        chk(20'h1, 20'h0);
      end else begin
        chk(mem_addr_o, wqa.pop_front());
        chk(mem_wdata_o, wqd.pop_front());
      end
    end
  end

  // Cuts a hang short well beyond the expected run length.
  initial begin
    #2000000;
    error_cnt++;
    tally_and_finish();
  end

  // Main sequence.
  initial begin
    void'($urandom(32'hEF75));
    for (int i = 0; i < 4096; i++) begin
      exp_mem[i] = 8'(i * 37 + 11);
    end
    repeat (10) @(negedge ref_clk_i);
    chk(fmt_o, FMT_NONE);
    chk(frame_pointer_o, 20'h0);
    chk(q1_o, 20'h1);
    rst_n_i = 1'b1;
    // Byte-oriented words with both flags random.
    for (int i = 0; i < 12; i++) begin
      w = {nibs[$urandom % 7], 12'($urandom)};
      issue(w);
      chk(fmt_o, FMT_BYTE);
      chk(opcode_o, w[15:10]);
      chk(result_to_file_o, w[9]);
      chk(bank_access_o, w[8]);
      chk(file_addr_o, efa(w, bank));
    end
    // Bit-oriented and literal words.
    for (int i = 0; i < 10; i++) begin
      w = {4'(7 + $urandom % 5), 12'($urandom)};
      issue(w);
      chk(fmt_o, FMT_BIT);
      chk(bit_pos_o, w[11:9]);
      chk(bank_access_o, w[8]);
      chk(file_addr_o, efa(w, bank));
      w = {4'h0, 12'($urandom)};
      issue(w);
      chk(fmt_o, FMT_LIT);
      chk(literal_o, w[7:0]);
    end
    // File-to-file moves.
    for (int i = 0; i < 3; i++) begin
      h = 12'($urandom);
      issue({4'hC, h});
      chk(fmt_o, FMT_F2F);
      chk(f2f_src_o, h);
      h = 12'($urandom);
      issue({4'hF, h});
      chk(f2f_dst_o, h);
    end
    // Jump and both call forms, then a jump with a bad second word.
    for (int i = 0; i < 4; i++) begin
      op = (i == 1) ? 8'hEC : (i == 2) ? 8'hED : 8'hEF;
      w = {op, 8'($urandom)};
      h = 12'($urandom);
      issue(w);
      chk(fmt_o, (op == 8'hEF) ? FMT_JUMP : FMT_CALL);
      chk(fast_return_o, op == 8'hED);
      chk(target_o, {12'h000, w[7:0]});
      issue((i == 3) ? {4'h7, h} : {4'hF, h});
      chk(word_err_o, i == 3);
      chk((i == 3) ? 20'(fmt_o) : target_o, (i == 3) ? 20'(FMT_NONE) : {h, w[7:0]});
    end
    // Indexed moves: edge addresses, indirect windows, then random frames.
    for (int i = 0; i < 13; i++) begin
      if (i < 7) begin
        fp_load(itab[i][25:14]);
        idx(itab[i][13:7], itab[i][6:0]);
      end else begin
        fp_load(12'($urandom % 12'hE00));
        idx(7'($urandom), 7'($urandom));
      end
    end
    // Push literal, including a frame pointer at zero.
    fp_load(12'h1EC);
    for (int i = 0; i < 4; i++) begin
      if (i == 3) begin
        instr_valid_i = 1'b0;
        fp_load(12'h000);
      end
      op = 8'($urandom);
      wqa.push_back(fp_m);
      wqd.push_back(op);
      issue({8'hFA, op});
      chk(fmt_o, FMT_PUSH);
      fp_m = fp_m - 12'h001;
      repeat (3) @(negedge ref_clk_i);
      chk(frame_pointer_o, fp_m);
    end
    instr_valid_i = 1'b0;
    repeat (8) @(negedge ref_clk_i);
    chk(20'(rq.size() + wqa.size()), 20'h0);
    tally_and_finish();
  end
endmodule
